// ===== verilog/tdc_pkg.sv
// package for the eight-bit dual compare timer core
// assumes a single system clock and a plain register port around the core
package tdc_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] ADDR_COUNT = 4'h2;
   localparam logic [3:0] ADDR_CMP_A = 4'h3;
   localparam logic [3:0] ADDR_CMP_B = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h5;
   localparam logic [3:0] ADDR_FLAG = 4'h6;
   localparam logic [3:0] ADDR_POWER = 4'h7;
   // counter extremes
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   // waveform modes
   localparam logic [2:0] WGM_NORMAL = 3'h0;
   localparam logic [2:0] WGM_PC_MAX = 3'h1;
   localparam logic [2:0] WGM_CTC = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] WGM_PC_OCRA = 3'h5;
   localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
   // clock select codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // prescaler width (divides up to 1024)
   localparam int PRESC_W = 10;
   // flag bit positions
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_POWER = 1'b1;
   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tdc_req_t;
   // interrupt acknowledge from the vector logic
   typedef struct packed {
      logic ovf;
      logic cmpa;
      logic cmpb;
   } tdc_ack_t;
endpackage : tdc_pkg

// ===== verilog/tdc_timer.sv
// eight-bit timer core with counter, two compare units and three flags
// assumes register port and interrupt acknowledges on i_clk_sys, pin is async
`timescale 1ns/1ns
module tdc_timer #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // register port
   input wire tdc_pkg::tdc_req_t i_req,
   output logic [7:0] o_rdata,
   // interrupt service acknowledges
   input wire tdc_pkg::tdc_ack_t i_ack,
   // external count pin
   input wire logic i_external_count_pin,
   // outputs
   output logic o_compare_a_output,
   output logic o_compare_b_output,
   output logic [2:0] o_irq
);
   // control and data registers
   logic [7:0] ctrl_a_reg;
   logic [7:0] ctrl_b_reg;
   logic [CNT_W-1:0] count_value_reg;
   logic [CNT_W-1:0] cmp_a_reg;
   logic [CNT_W-1:0] cmp_b_reg;
   logic [CNT_W-1:0] buf_a_reg;
   logic [CNT_W-1:0] buf_b_reg;
   logic [2:0] timer_mask_reg;
   logic [2:0] timer_flag_reg;
   logic timer_power_reduce_bit_reg;
   logic dir_down_reg;
   logic block_reg;
   logic [tdc_pkg::PRESC_W-1:0] presc_reg;
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic pin_s3_reg;
   logic [7:0] rdata_next;

   // field decode
   wire [2:0] clock_select_field = ctrl_b_reg[2:0];
   wire waveform_mode_bit0 = ctrl_a_reg[0];
   wire waveform_mode_bit1 = ctrl_a_reg[1];
   wire waveform_mode_bit2 = ctrl_b_reg[3];
   wire [2:0] waveform_mode_field = {waveform_mode_bit2, waveform_mode_bit1,
      waveform_mode_bit0};
   wire [1:0] compare_output_mode_a = ctrl_a_reg[7:6];
   wire [1:0] compare_output_mode_b = ctrl_a_reg[5:4];
   wire force_compare_strobe_a = i_req.wr && i_req.addr == tdc_pkg::ADDR_CTRL_B
      && i_req.wdata[7];
   wire force_compare_strobe_b = i_req.wr && i_req.addr == tdc_pkg::ADDR_CTRL_B
      && i_req.wdata[6];

   // mode classes
   wire mode_pwm = waveform_mode_field[0]; // modes 1,3,5,7 are pwm
   wire mode_fast = mode_pwm && waveform_mode_field[1];
   wire mode_pc = mode_pwm && !waveform_mode_field[1];
   wire mode_ctc = waveform_mode_field == tdc_pkg::WGM_CTC;
   wire top_is_cmpa = mode_ctc || (mode_pwm && waveform_mode_field[2]);

   // write strobes
   wire wr_count = i_req.wr && i_req.addr == tdc_pkg::ADDR_COUNT;
   wire wr_cmp_a = i_req.wr && i_req.addr == tdc_pkg::ADDR_CMP_A;
   wire wr_cmp_b = i_req.wr && i_req.addr == tdc_pkg::ADDR_CMP_B;
   wire wr_flag = i_req.wr && i_req.addr == tdc_pkg::ADDR_FLAG;

   // prescaler taps
   function automatic logic tap_hit(input logic [tdc_pkg::PRESC_W-1:0] p,
      input int bits);
      logic [tdc_pkg::PRESC_W-1:0] m;
      m = tdc_pkg::PRESC_W'((1 << bits) - 1);
      tap_hit = (p & m) == m;
   endfunction : tap_hit

   // pin edge detect reads only the second and third stages
   wire pin_rise = pin_s2_reg && !pin_s3_reg;
   wire pin_fall = !pin_s2_reg && pin_s3_reg;

   // timer tick select
   logic timer_tick;
   always_comb begin
      case (clock_select_field)
         tdc_pkg::CS_STOP: timer_tick = 1'b0;
         tdc_pkg::CS_DIV1: timer_tick = 1'b1;
         tdc_pkg::CS_DIV8: timer_tick = tap_hit(presc_reg, 3);
         tdc_pkg::CS_DIV64: timer_tick = tap_hit(presc_reg, 6);
         tdc_pkg::CS_DIV256: timer_tick = tap_hit(presc_reg, 8);
         tdc_pkg::CS_DIV1024: timer_tick = tap_hit(presc_reg, 10);
         tdc_pkg::CS_EXT_FALL: timer_tick = pin_fall;
         default: timer_tick = pin_rise;
      endcase
   end
   wire tick = timer_tick && !timer_power_reduce_bit_reg;

   // extremes and top
   wire at_bottom = count_value_reg == tdc_pkg::CNT_BOTTOM;
   wire at_max = count_value_reg == tdc_pkg::CNT_MAX;
   wire [CNT_W-1:0] top_value = top_is_cmpa ? cmp_a_reg : tdc_pkg::CNT_MAX;
   wire at_top = count_value_reg == top_value;

   // comparator with blocking after counter writes
   wire match_a = (count_value_reg == cmp_a_reg) && !block_reg;
   wire match_b = (count_value_reg == cmp_b_reg) && !block_reg;

   // counter next value
   logic [CNT_W-1:0] count_next;
   logic dir_next;
   always_comb begin
      count_next = count_value_reg;
      dir_next = dir_down_reg;
      if (wr_count) begin
         count_next = i_req.wdata;
      end else if (tick) begin
         if (mode_pc) begin
            if (at_top) begin
               dir_next = 1'b1;
            end else if (at_bottom) begin
               dir_next = 1'b0;
            end
            if (dir_next) begin
               count_next = count_value_reg - 1'b1;
            end else begin
               count_next = count_value_reg + 1'b1;
            end
         end else if (top_is_cmpa && at_top) begin
            count_next = tdc_pkg::CNT_BOTTOM;
         end else begin
            count_next = count_value_reg + 1'b1;
         end
      end
   end

   // overflow point by mode
   wire ovf_event = tick && !wr_count && (mode_pc ? at_bottom && dir_down_reg
      : (mode_fast ? at_top : at_max));

   // buffer load point and host path
   wire load_buf = tick && (mode_pc ? at_top : at_bottom);
   logic [CNT_W-1:0] cmp_a_next;
   logic [CNT_W-1:0] cmp_b_next;
   always_comb begin
      cmp_a_next = cmp_a_reg;
      cmp_b_next = cmp_b_reg;
      if (!mode_pwm) begin
         if (wr_cmp_a) cmp_a_next = i_req.wdata;
         if (wr_cmp_b) cmp_b_next = i_req.wdata;
      end else if (load_buf) begin
         cmp_a_next = buf_a_reg;
         cmp_b_next = buf_b_reg;
      end
   end

   // waveform action per unit
   function automatic logic wave_next(input logic cur, input logic [1:0] com,
      input logic fire, input logic pwm, input logic fast, input logic dn,
      input logic top_evt);
      wave_next = cur;
      if (!pwm) begin
         if (fire) begin
            case (com)
               2'h1: wave_next = !cur;
               2'h2: wave_next = 1'b0;
               2'h3: wave_next = 1'b1;
               default: wave_next = cur;
            endcase
         end
      end else if (com[1]) begin
         if (fast) begin
            if (fire) wave_next = com[0];
            else if (top_evt) wave_next = !com[0];
         end else if (fire) begin
            wave_next = dn ? !com[0] : com[0];
         end
      end
   endfunction : wave_next

   wire fire_a = (tick && match_a) || (!mode_pwm && force_compare_strobe_a);
   wire fire_b = (tick && match_b) || (!mode_pwm && force_compare_strobe_b);
   wire wave_a_next = wave_next(o_compare_a_output, compare_output_mode_a, fire_a,
      mode_pwm, mode_fast, dir_down_reg, tick && at_top);
   wire wave_b_next = wave_next(o_compare_b_output, compare_output_mode_b, fire_b,
      mode_pwm, mode_fast, dir_down_reg, tick && at_top);

   // flags: set wins over clear
   wire [2:0] flag_set = {tick && match_b, tick && match_a, ovf_event};
   wire [2:0] flag_clr = (wr_flag ? i_req.wdata[2:0] : 3'h0) | {i_ack.cmpb,
      i_ack.cmpa, i_ack.ovf};
   wire [2:0] flag_next = (timer_flag_reg & ~flag_clr) | flag_set;

   // read mux
   always_comb begin
      rdata_next = 8'h00;
      if (i_req.addr == tdc_pkg::ADDR_CTRL_A) rdata_next = ctrl_a_reg;
      else if (i_req.addr == tdc_pkg::ADDR_CTRL_B) rdata_next = {2'h0, ctrl_b_reg[5:0]};
      else if (i_req.addr == tdc_pkg::ADDR_COUNT) rdata_next = count_value_reg;
      else if (i_req.addr == tdc_pkg::ADDR_CMP_A) rdata_next = mode_pwm ? buf_a_reg : cmp_a_reg;
      else if (i_req.addr == tdc_pkg::ADDR_CMP_B) rdata_next = mode_pwm ? buf_b_reg : cmp_b_reg;
      else if (i_req.addr == tdc_pkg::ADDR_MASK) rdata_next = {5'h0, timer_mask_reg};
      else if (i_req.addr == tdc_pkg::ADDR_FLAG) rdata_next = {5'h0, timer_flag_reg};
      else if (i_req.addr == tdc_pkg::ADDR_POWER) rdata_next = {7'h0, timer_power_reduce_bit_reg};
   end

   // pin synchroniser and prescaler
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
         presc_reg <= '0;
      end else begin
         pin_s1_reg <= i_external_count_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         presc_reg <= presc_reg + 1'b1;
      end
   end

   // host control registers
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_a_reg <= tdc_pkg::RST_BYTE;
         ctrl_b_reg <= tdc_pkg::RST_BYTE;
         timer_mask_reg <= 3'h0;
         timer_power_reduce_bit_reg <= tdc_pkg::RST_POWER;
         buf_a_reg <= tdc_pkg::RST_BYTE;
         buf_b_reg <= tdc_pkg::RST_BYTE;
      end else if (i_req.wr) begin
         if (i_req.addr == tdc_pkg::ADDR_CTRL_A) ctrl_a_reg <= i_req.wdata;
         if (i_req.addr == tdc_pkg::ADDR_CTRL_B) ctrl_b_reg <= {2'h0, i_req.wdata[5:0]};
         if (i_req.addr == tdc_pkg::ADDR_MASK) timer_mask_reg <= i_req.wdata[2:0];
         if (i_req.addr == tdc_pkg::ADDR_POWER) timer_power_reduce_bit_reg <= i_req.wdata[0];
         if (wr_cmp_a) buf_a_reg <= i_req.wdata;
         if (wr_cmp_b) buf_b_reg <= i_req.wdata;
      end
   end

   // counter, compare and block state
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count_value_reg <= tdc_pkg::RST_BYTE;
         dir_down_reg <= 1'b0;
         cmp_a_reg <= tdc_pkg::RST_BYTE;
         cmp_b_reg <= tdc_pkg::RST_BYTE;
         block_reg <= 1'b0;
      end else begin
         count_value_reg <= count_next;
         dir_down_reg <= mode_pc ? dir_next : 1'b0;
         cmp_a_reg <= cmp_a_next;
         cmp_b_reg <= cmp_b_next;
         if (wr_count) block_reg <= 1'b1;
         else if (tick) block_reg <= 1'b0;
      end
   end

   // flags, outputs and read data
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         timer_flag_reg <= 3'h0;
         o_irq <= 3'h0;
         o_compare_a_output <= 1'b0;
         o_compare_b_output <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         timer_flag_reg <= flag_next;
         o_irq <= flag_next & timer_mask_reg;
         o_compare_a_output <= wave_a_next;
         o_compare_b_output <= wave_b_next;
         o_rdata <= i_req.rd ? rdata_next : 8'h00;
      end
   end

   // checks
   a_flag_set_cmpa: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      tick && match_a |=> timer_flag_reg[tdc_pkg::FLAG_CMPA])
      else $error("compare a flag not set after match");
   a_count_write_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_count |=> count_value_reg == $past(i_req.wdata))
      else $error("counter write lost");
   a_stop_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      clock_select_field == tdc_pkg::CS_STOP && !wr_count |=> $stable(count_value_reg))
      else $error("counter moved while stopped");
   a_power_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      timer_power_reduce_bit_reg && !wr_count |=> $stable(count_value_reg))
      else $error("counter moved while powered down");
   a_block_match: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_count ##1 !tick[*2] |-> !match_a && !match_b)
      else $error("match not blocked after counter write");
   a_normal_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      waveform_mode_field == tdc_pkg::WGM_NORMAL && tick && at_max && !wr_count
      |=> count_value_reg == tdc_pkg::CNT_BOTTOM && timer_flag_reg[tdc_pkg::FLAG_OVF])
      else $error("normal mode wrap or overflow wrong");
   a_ctc_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      mode_ctc && tick && at_top && !wr_count |=> count_value_reg == tdc_pkg::CNT_BOTTOM)
      else $error("ctc clear missing");
   a_flag_write_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flag && i_req.wdata[0] && !ovf_event |=> !timer_flag_reg[tdc_pkg::FLAG_OVF])
      else $error("flag not cleared by one");
   a_flag_write_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_flag && !i_req.wdata[1] && !i_ack.cmpa && timer_flag_reg[1] |=> timer_flag_reg[1])
      else $error("flag cleared by zero");
   a_irq_masked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      ##1 o_irq == (timer_flag_reg & $past(timer_mask_reg)))
      else $error("interrupt gating wrong");

   c_ovf: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) ovf_event);
   c_match_b: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) tick && match_b);
   c_force: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      force_compare_strobe_a && !mode_pwm);
   c_buf_load: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      load_buf && mode_pwm);
endmodule : tdc_timer

// ===== test/tb_timer8_dual_compare_core.sv
// self-checking bench for the eight-bit dual compare timer core
// assumes the core alone, driven on i_clk_sys at 20 MHz over its register port
`timescale 1ns/1ns
module tb_timer8_dual_compare_core;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   tdc_pkg::tdc_req_t i_req = '0;
   tdc_pkg::tdc_ack_t i_ack = '0;
   logic i_external_count_pin = 1'b0;
   logic [7:0] o_rdata;
   logic o_compare_a_output;
   logic o_compare_b_output;
   logic [2:0] o_irq;
   int n_fail = 0;
   int total_checks = 0;
   logic [7:0] v;
   logic a0;
   logic b0;

   // 50 ns system clock
   always #25 i_clk_sys = ~i_clk_sys;

   tdc_timer dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata),
      .i_ack(i_ack), .i_external_count_pin(i_external_count_pin),
      .o_compare_a_output(o_compare_a_output), .o_compare_b_output(o_compare_b_output),
      .o_irq(o_irq));

   task automatic cycles(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : cycles

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      i_req.wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      i_req.rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // run the counter on code cs for n cycles, then stop it
   task automatic run(input logic [7:0] cs, input int n);
      wr(tdc_pkg::ADDR_CTRL_B, cs);
      cycles(n);
      wr(tdc_pkg::ADDR_CTRL_B, 8'h00);
   endtask : run

   task automatic t_reset_values();
      for (int i = 0; i < 10; i++) begin
         rd(i[3:0], v);
         check(v, (i == 7) ? 8'h01 : 8'h00);
      end
      wr(tdc_pkg::ADDR_POWER, 8'h00);
   endtask : t_reset_values

   task automatic t_overflow();
      wr(tdc_pkg::ADDR_CMP_A, 8'h10);
      wr(tdc_pkg::ADDR_CMP_B, 8'h80);
      wr(tdc_pkg::ADDR_FLAG, 8'hff);
      wr(tdc_pkg::ADDR_COUNT, 8'hfe);
      run(8'h01, 6);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h01);
      check({5'h0, o_irq}, 8'h00);
      wr(tdc_pkg::ADDR_MASK, 8'h01);
      cycles(2);
      check({5'h0, o_irq}, 8'h01);
      wr(tdc_pkg::ADDR_FLAG, 8'h00);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h01);
      wr(tdc_pkg::ADDR_FLAG, 8'h01);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
   endtask : t_overflow

   task automatic t_compare();
      wr(tdc_pkg::ADDR_COUNT, 8'h0c);
      run(8'h01, 10);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h02);
      wr(tdc_pkg::ADDR_MASK, 8'h02);
      cycles(2);
      check({5'h0, o_irq}, 8'h02);
      @(posedge i_clk_sys);
      i_ack.cmpa <= 1'b1;
      @(posedge i_clk_sys);
      i_ack.cmpa <= 1'b0;
      cycles(2);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
      check({5'h0, o_irq}, 8'h00);
   endtask : t_compare

   task automatic t_block();
      wr(tdc_pkg::ADDR_CMP_B, 8'h33);
      wr(tdc_pkg::ADDR_COUNT, 8'h33);
      run(8'h01, 3);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
   endtask : t_block

   task automatic t_ctc();
      wr(tdc_pkg::ADDR_CTRL_A, 8'h02);
      wr(tdc_pkg::ADDR_CMP_A, 8'h05);
      wr(tdc_pkg::ADDR_COUNT, 8'h00);
      run(8'h01, 40);
      rd(tdc_pkg::ADDR_COUNT, v);
      check({7'h0, v <= 8'h05}, 8'h01);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h02);
      wr(tdc_pkg::ADDR_FLAG, 8'hff);
      wr(tdc_pkg::ADDR_CTRL_A, 8'h00);
   endtask : t_ctc

   // one timer tick per selected pin edge
   task automatic t_pin(input logic [7:0] cs);
      wr(tdc_pkg::ADDR_COUNT, 8'h00);
      wr(tdc_pkg::ADDR_CTRL_B, cs);
      for (int i = 0; i < 5; i++) begin
         i_external_count_pin <= 1'b1;
         cycles(4);
         i_external_count_pin <= 1'b0;
         cycles(4);
      end
      cycles(6);
      wr(tdc_pkg::ADDR_CTRL_B, 8'h00);
      rd(tdc_pkg::ADDR_COUNT, v);
      check(v, 8'h05);
   endtask : t_pin

   task automatic t_prescale();
      int dv;
      for (int c = 1; c < 6; c++) begin
         dv = (c == 1) ? 4 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
         wr(tdc_pkg::ADDR_COUNT, 8'h00);
         run(c[7:0], 4 * dv);
         rd(tdc_pkg::ADDR_COUNT, v);
         if (c == 1) check({7'h0, v >= 8'd15 && v <= 8'd19}, 8'h01);
         else check({7'h0, v >= 8'd3 && v <= 8'd5}, 8'h01);
      end
   endtask : t_prescale

   task automatic t_buffer();
      wr(tdc_pkg::ADDR_FLAG, 8'hff);
      wr(tdc_pkg::ADDR_CTRL_A, 8'h03);
      wr(tdc_pkg::ADDR_CMP_B, 8'h44);
      rd(tdc_pkg::ADDR_CMP_B, v);
      check(v, 8'h44);
      wr(tdc_pkg::ADDR_COUNT, 8'h40);
      run(8'h01, 8);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
      wr(tdc_pkg::ADDR_COUNT, 8'hfc);
      run(8'h01, 80);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h07);
      wr(tdc_pkg::ADDR_FLAG, 8'hff);
   endtask : t_buffer

   // phase correct mode turns at max and counts down without overflow
   task automatic t_phase();
      wr(tdc_pkg::ADDR_CTRL_A, 8'h01);
      wr(tdc_pkg::ADDR_COUNT, 8'hfd);
      run(8'h01, 3);
      rd(tdc_pkg::ADDR_COUNT, v);
      check(v, 8'hfc);
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
      wr(tdc_pkg::ADDR_CTRL_A, 8'h00);
   endtask : t_phase

   task automatic t_force();
      wr(tdc_pkg::ADDR_CTRL_A, 8'h50);
      a0 = o_compare_a_output;
      b0 = o_compare_b_output;
      wr(tdc_pkg::ADDR_CTRL_B, 8'hc0);
      cycles(2);
      check({7'h0, o_compare_a_output}, {7'h0, ~a0});
      check({7'h0, o_compare_b_output}, {7'h0, ~b0});
      rd(tdc_pkg::ADDR_FLAG, v);
      check(v, 8'h00);
      wr(tdc_pkg::ADDR_CTRL_A, 8'h53);
      a0 = o_compare_a_output;
      b0 = o_compare_b_output;
      wr(tdc_pkg::ADDR_CTRL_B, 8'hc0);
      cycles(2);
      check({7'h0, o_compare_a_output}, {7'h0, a0});
      check({7'h0, o_compare_b_output}, {7'h0, b0});
      wr(tdc_pkg::ADDR_CTRL_A, 8'h00);
   endtask : t_force

   task automatic t_write_wins();
      wr(tdc_pkg::ADDR_CTRL_B, 8'h01);
      wr(tdc_pkg::ADDR_COUNT, 8'h77);
      wr(tdc_pkg::ADDR_CTRL_B, 8'h00);
      rd(tdc_pkg::ADDR_COUNT, v);
      check({7'h0, v >= 8'h77 && v <= 8'h79}, 8'h01);
   endtask : t_write_wins

   task automatic t_power();
      wr(tdc_pkg::ADDR_COUNT, 8'h20);
      wr(tdc_pkg::ADDR_POWER, 8'h01);
      run(8'h01, 20);
      wr(tdc_pkg::ADDR_POWER, 8'h00);
      rd(tdc_pkg::ADDR_COUNT, v);
      check(v, 8'h20);
   endtask : t_power

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   // main sequence
   initial begin
      cycles(20);
      i_rst_b <= 1'b1;
      t_reset_values();
      t_overflow();
      t_compare();
      t_block();
      t_ctc();
      t_pin(8'h07);
      t_pin(8'h06);
      t_prescale();
      t_buffer();
      t_phase();
      t_force();
      t_write_wins();
      t_power();
      report_and_stop();
   end

   // watchdog, well beyond the roughly 6000 cycles the tests need
   initial begin
      #2000000;
      n_fail++;
      report_and_stop();
   end
endmodule : tb_timer8_dual_compare_core
